// [hdl/cms_pkg.sv]
// Package of constants and carrier types for the CAN mode/status block.
package cms_pkg;

   // ========================================================
   // Register offsets (byte addresses on the APB side)
   localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
   localparam logic [7:0] OFS_COMM_STAT = 8'h04;
   localparam logic [7:0] OFS_TXCON0 = 8'h08;
   localparam logic [7:0] OFS_OPMODE = 8'h14;
   localparam logic [7:0] OFS_ERRCNT = 8'h18;
   localparam logic [7:0] OFS_TXDATA0 = 8'h1c;
   localparam int NUM_TXBUF = 3;

   // ========================================================
   // Field positions
   localparam int MDSEL_LSB = 6;
   localparam int FIFO_WATERMARK_SELECT_BIT = 5;
   localparam int OVF0_BIT = 7;
   localparam int OVF1_BIT = 6;
   localparam int TXDONE_BIT = 7;
   localparam int TX_ABORTED_STATUS_BIT = 6;
   localparam int TX_LOST_ARBITRATION_STATUS_BIT = 5;
   localparam int TX_BUS_ERROR_STATUS_BIT = 4;
   localparam int TX_REQUEST_BIT = 3;
   localparam int OPST_LSB = 8;
   localparam int REC_LSB = 16;

   // ========================================================
   // Reset values
   localparam logic [7:0] MODE_CTRL_RST = 8'h10;
   localparam logic [2:0] OPREQ_RST = 3'h4;

   // ========================================================
   // Operating-mode select and status codes
   localparam logic [1:0] MD_LEGACY = 2'h0;
   localparam logic [1:0] MD_ENH_LEGACY = 2'h1;
   localparam logic [1:0] MD_FIFO = 2'h2;
   localparam logic [2:0] OPC_NORMAL = 3'h0;
   localparam logic [2:0] OPC_SLEEP = 3'h1;
   localparam logic [2:0] OPC_LOOP = 3'h2;
   localparam logic [2:0] OPC_LISTEN = 3'h3;
   localparam logic [2:0] OPC_CONFIG = 3'h4;
   typedef enum logic [2:0] {
      OP_NORMAL, OP_SLEEP, OP_LOOP, OP_LISTEN, OP_CONFIG
   } cms_op_t;

   // ========================================================
   // Error counter thresholds and steps, FIFO watermark levels
   localparam logic [8:0] WARN_LIM = 9'h05f;
   localparam logic [8:0] PASSIVE_LIM = 9'h07f;
   localparam logic [8:0] BUSOFF_LIM = 9'h0ff;
   localparam logic [8:0] TEC_STEP = 9'h008;
   localparam logic [7:0] REC_MAX = 8'hff;
   localparam logic [7:0] REC_PASSIVE = 8'h7f;
   localparam logic [7:0] RECOV_RUNS = 8'h80;
   localparam logic [3:0] WM_LOW = 4'h1;
   localparam logic [3:0] WM_HIGH = 4'h4;
   localparam logic [3:0] SHORT_FIFO = 4'h4;

   // ========================================================
   // Window classes
   typedef enum logic [2:0] {
      WIN_NONE, WIN_FILTER, WIN_MASK, WIN_TXBUF, WIN_RXBUF, WIN_CFGBUF
   } cms_win_t;

   // ========================================================
   // Carrier types
   typedef struct packed {
      logic tx_ok;
      logic tx_err;
      logic rx_ok;
      logic rx_err;
      logic recessive_run;
   } cms_fault_ev_t;

   typedef struct packed {
      logic done;
      logic lost_arb;
      logic bus_err;
      logic withdrawn;
      logic [1:0] idx;
   } cms_tx_ev_t;

   typedef struct packed {
      logic valid;
      logic [1:0] idx;
   } cms_tx_sel_t;

   typedef struct packed {
      cms_win_t kind;
      logic [2:0] index;
   } cms_window_t;

endpackage : cms_pkg

// [hdl/cms_ctrl.sv]
// CAN mode control, communication status and transmit buffer control.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Mode select: 00 legacy, 01 enhanced, 10 FIFO
// - Mode select writable only in configuration mode
// - New mode select applies on leaving configuration
// - FIFO watermark: one or four free buffers
// - Short FIFO forces watermark bit set
// - Window field maps banked group; legacy reads zero
// - Window codes for filters and the single mask
// - Window codes for tx, rx, configurable buffers
// - Legacy bit 7: clearable rx buffer 0 overflow
// - FIFO mode bit 7: FIFO not empty
// - Bit 6: clearable overflow flag, per mode
// - Bus-off flag when tx count above 255
// - Error-passive flags above 127 each
// - Warning flags between 96 and 127
// - Combined warning is OR of both warnings
// - Enhanced modes: clearable transmit done flag
// - Setting request clears abort, arbitration, error
// - Request self-clears after successful send
// - Clearing pending request means abort request
// - Lost arbitration and bus error status bits
// - Pending buffer registers ignore writes
// - Two-bit priority orders pending buffers
// - Operating-mode status codes 100..000
// - Configuration entry waits for idle bus
// - 128 recessive runs clear tx error count
module cms_ctrl (
   // APB slave.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Protocol engine side.
   input wire logic bus_idle,
   input wire cms_pkg::cms_fault_ev_t fault_ev,
   input wire cms_pkg::cms_tx_ev_t tx_ev,
   output cms_pkg::cms_tx_sel_t tx_sel,
   output logic [2:0] tx_abort_req,
   output logic [95:0] tx_payload,
   // Receive side.
   input wire logic rx_buf0_overflow,
   input wire logic rx_buf1_overflow,
   input wire logic [3:0] rx_fifo_len,
   input wire logic [3:0] rx_fifo_used,
   output logic fifo_watermark_irq,
   // Mode and window outputs.
   output logic [1:0] active_mode,
   output logic [2:0] operating_mode_status,
   output cms_pkg::cms_window_t window_map
);

   // ========================================================
   // Bus decode
   logic acc;
   logic wr;
   logic hit_mode;
   logic hit_stat;
   logic hit_op;
   logic hit_cnt;
   logic [2:0] hit_txcon;
   logic [2:0] hit_txdat;
   logic mapped;

   // A write lands in the access phase; the slave never stalls.
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign pready = 1'b1;
   assign hit_mode = (paddr == cms_pkg::OFS_MODE_CTRL);
   assign hit_stat = (paddr == cms_pkg::OFS_COMM_STAT);
   assign hit_op = (paddr == cms_pkg::OFS_OPMODE);
   assign hit_cnt = (paddr == cms_pkg::OFS_ERRCNT);
   assign mapped = hit_mode | hit_stat | hit_op | hit_cnt
                   | (|hit_txcon) | (|hit_txdat);
   assign pslverr = acc & ~mapped;

   // ========================================================
   // Operating mode
   logic [2:0] op_req;
   cms_pkg::cms_op_t op_state;
   cms_pkg::cms_op_t next_op;
   logic [7:0] mode_ctrl;
   logic [1:0] pending_mdsel;
   logic in_config;

   assign in_config = (op_state == cms_pkg::OP_CONFIG);

   // Software request for the operating mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_req <= cms_pkg::OPREQ_RST;
      end else if (wr && hit_op) begin
         op_req <= pwdata[2:0];
      end
   end

   // Configuration entry waits for an idle bus, codes 0 to 3 act at once, codes 5 to 7 hold.
   always_comb begin
      next_op = op_state;
      case (op_req)
         cms_pkg::OPC_CONFIG: begin
            if (bus_idle) begin
               next_op = cms_pkg::OP_CONFIG;
            end
         end
         cms_pkg::OPC_NORMAL: next_op = cms_pkg::OP_NORMAL;
         cms_pkg::OPC_SLEEP: next_op = cms_pkg::OP_SLEEP;
         cms_pkg::OPC_LOOP: next_op = cms_pkg::OP_LOOP;
         cms_pkg::OPC_LISTEN: next_op = cms_pkg::OP_LISTEN;
         default: next_op = op_state;
      endcase
   end

   // The state register starts in configuration mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_state <= cms_pkg::OP_CONFIG;
      end else begin
         op_state <= next_op;
      end
   end

   // Status code of the current operating mode.
   always_comb begin
      case (op_state)
         cms_pkg::OP_NORMAL: operating_mode_status = cms_pkg::OPC_NORMAL;
         cms_pkg::OP_SLEEP: operating_mode_status = cms_pkg::OPC_SLEEP;
         cms_pkg::OP_LOOP: operating_mode_status = cms_pkg::OPC_LOOP;
         cms_pkg::OP_LISTEN: operating_mode_status = cms_pkg::OPC_LISTEN;
         default: operating_mode_status = cms_pkg::OPC_CONFIG;
      endcase
   end

   // ========================================================
   // Mode control register
   logic short_fifo;

   assign short_fifo = (rx_fifo_len <= cms_pkg::SHORT_FIFO);
   assign pending_mdsel = mode_ctrl[cms_pkg::MDSEL_LSB +: 2];

   // Mode select moves only in configuration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ctrl <= cms_pkg::MODE_CTRL_RST;
      end else begin
         if (wr && hit_mode) begin
            mode_ctrl[5:0] <= pwdata[5:0];
            if (in_config) begin
               mode_ctrl[7:6] <= pwdata[7:6];
            end
         end
         if (short_fifo) begin
            mode_ctrl[cms_pkg::FIFO_WATERMARK_SELECT_BIT] <= 1'b1;
         end
      end
   end

   // The selection takes effect as configuration mode is left.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_mode <= cms_pkg::MD_LEGACY;
      end else if (in_config && next_op != cms_pkg::OP_CONFIG) begin
         active_mode <= pending_mdsel;
      end
   end

   logic enhanced;
   logic fifo_mode;
   logic [4:0] win_sel;
   logic [3:0] free_bufs;

   // Code 11 is reserved and behaves as legacy.
   assign enhanced = (active_mode == cms_pkg::MD_ENH_LEGACY) | fifo_mode;
   assign fifo_mode = (active_mode == cms_pkg::MD_FIFO);
   assign win_sel = enhanced ? mode_ctrl[4:0] : 5'h0_0;
   assign free_bufs = rx_fifo_len - rx_fifo_used;

   // Watermark interrupt level, FIFO mode only.
   assign fifo_watermark_irq = fifo_mode & (mode_ctrl[cms_pkg::FIFO_WATERMARK_SELECT_BIT]
      ? (free_bufs <= cms_pkg::WM_LOW)
      : (free_bufs <= cms_pkg::WM_HIGH));

   // Decode of the window code into the mapped register group.
   always_comb begin
      window_map.index = 3'h0;
      window_map.kind = cms_pkg::WIN_NONE;
      if (enhanced) begin
         case (win_sel)
            5'h00, 5'h01, 5'h06, 5'h07, 5'h08, 5'h09: begin
               window_map.kind = cms_pkg::WIN_FILTER;
               window_map.index = (win_sel < 5'h02) ? win_sel[2:0]
                                  : 3'(win_sel[2:0] - 3'h4);
            end
            5'h02: window_map.kind = cms_pkg::WIN_MASK;
            5'h03, 5'h04, 5'h05: begin
               window_map.kind = cms_pkg::WIN_TXBUF;
               window_map.index = 3'(win_sel[2:0] - 3'h3);
            end
            5'h10, 5'h11: begin
               window_map.kind = cms_pkg::WIN_RXBUF;
               window_map.index = win_sel[2:0];
            end
            5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17: begin
               window_map.kind = cms_pkg::WIN_CFGBUF;
               window_map.index = 3'(win_sel[2:0] - 3'h2);
            end
            default: window_map.kind = cms_pkg::WIN_NONE;
         endcase
      end
   end

   // ========================================================
   // Error counters
   logic [8:0] tec;
   logic [7:0] rec;
   logic [7:0] recov_cnt;
   logic busoff;

   assign busoff = (tec > cms_pkg::BUSOFF_LIM);

   // Transmit counter: +8 per error, -1 per success, cleared on recovery.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tec <= 9'h000;
         recov_cnt <= 8'h00;
      end else if (busoff) begin
         if (fault_ev.recessive_run) begin
            if (recov_cnt == 8'(cms_pkg::RECOV_RUNS - 8'h01)) begin
               tec <= 9'h000;
               recov_cnt <= 8'h00;
            end else begin
               recov_cnt <= recov_cnt + 8'h01;
            end
         end
      end else if (fault_ev.tx_err) begin
         tec <= tec + cms_pkg::TEC_STEP;
      end else if (fault_ev.tx_ok && tec != 9'h000) begin
         tec <= tec - 9'h001;
      end
   end

   // Receive counter: +1 per error up to 255, -1 per success; success above 127 drops to 127.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec <= 8'h00;
      end else if (fault_ev.rx_err && rec != cms_pkg::REC_MAX) begin
         rec <= rec + 8'h01;
      end else if (fault_ev.rx_ok && !fault_ev.rx_err) begin
         if (rec > cms_pkg::REC_PASSIVE) begin
            rec <= cms_pkg::REC_PASSIVE;
         end else if (rec != 8'h00) begin
            rec <= rec - 8'h01;
         end
      end
   end

   // ========================================================
   // Communication status
   logic [8:0] rec_w;
   logic tx_passive;
   logic rx_passive;
   logic tx_warn;
   logic rx_warn;
   logic ovf_hi;
   logic ovf_lo;
   logic [7:0] comm_stat;

   assign rec_w = {1'b0, rec};
   assign tx_passive = (tec > cms_pkg::PASSIVE_LIM);
   assign rx_passive = (rec_w > cms_pkg::PASSIVE_LIM);
   assign tx_warn = (tec > cms_pkg::WARN_LIM) & ~tx_passive;
   assign rx_warn = (rec_w > cms_pkg::WARN_LIM) & ~rx_passive;

   // Overflow flags; writing zero clears, a new overflow wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_hi <= 1'b0;
         ovf_lo <= 1'b0;
      end else begin
         if (!enhanced && rx_buf0_overflow) begin
            ovf_hi <= 1'b1;
         end else if (wr && hit_stat && !pwdata[cms_pkg::OVF0_BIT]) begin
            ovf_hi <= 1'b0;
         end
         if (enhanced ? (rx_buf0_overflow | rx_buf1_overflow)
                      : rx_buf1_overflow) begin
            ovf_lo <= 1'b1;
         end else if (wr && hit_stat && !pwdata[cms_pkg::OVF1_BIT]) begin
            ovf_lo <= 1'b0;
         end
      end
   end

   // Bit 7 depends on the active mode.
   always_comb begin
      comm_stat = {1'b0, ovf_lo, busoff, tx_passive, rx_passive,
                   tx_warn, rx_warn, tx_warn | rx_warn};
      if (fifo_mode) begin
         comm_stat[7] = (rx_fifo_used != 4'h0);
      end else if (!enhanced) begin
         comm_stat[7] = ovf_hi;
      end
   end

   // ========================================================
   // Transmit buffers
   logic [2:0] req;
   logic [7:0] txcon [3];
   logic [31:0] txdat [3];

   genvar n;
   generate
      for (n = 0; n < cms_pkg::NUM_TXBUF; n++) begin : g_buf
         logic ev;
         logic wcon;
         logic abt;
         logic larb;
         logic err;
         logic done;
         logic abort_pend;
         logic [1:0] pri;
         logic start;

         assign hit_txcon[n] = (paddr == 8'(cms_pkg::OFS_TXCON0 + 4 * n));
         assign hit_txdat[n] = (paddr == 8'(cms_pkg::OFS_TXDATA0 + 4 * n));
         assign ev = (tx_ev.idx == 2'(n));
         assign wcon = wr & hit_txcon[n];
         assign start = wcon & pwdata[cms_pkg::TX_REQUEST_BIT] & ~req[n];

         // Request bit: set by software, cleared by success or withdrawal.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               req[n] <= 1'b0;
            end else if (ev && (tx_ev.done || tx_ev.withdrawn)) begin
               req[n] <= 1'b0;
            end else if (start) begin
               req[n] <= 1'b1;
            end
         end

         // Clearing a pending request asks the engine to withdraw it.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               abort_pend <= 1'b0;
            end else if (!req[n]) begin
               abort_pend <= 1'b0;
            end else if (wcon && !pwdata[cms_pkg::TX_REQUEST_BIT]) begin
               abort_pend <= 1'b1;
            end
         end

         // Status bits: events set them, a new request clears them.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               abt <= 1'b0;
               larb <= 1'b0;
               err <= 1'b0;
            end else begin
               abt <= (ev & tx_ev.withdrawn) | (abt & ~start);
               larb <= (ev & tx_ev.lost_arb) | (larb & ~start);
               err <= (ev & tx_ev.bus_err) | (err & ~start);
            end
         end

         // Done flag in enhanced modes; writing zero clears it.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               done <= 1'b0;
            end else if (ev && tx_ev.done && enhanced) begin
               done <= 1'b1;
            end else if (wcon && !pwdata[cms_pkg::TXDONE_BIT]) begin
               done <= 1'b0;
            end
         end

         // Priority and payload are frozen while a request is pending.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pri <= 2'h0;
               txdat[n] <= 32'h0000_0000;
            end else if (!req[n]) begin
               if (wcon) begin
                  pri <= pwdata[1:0];
               end
               if (wr && hit_txdat[n]) begin
                  txdat[n] <= pwdata;
               end
            end
         end

         assign txcon[n] = {done & enhanced, abt, larb, err, req[n], 1'b0, pri};
         assign tx_abort_req[n] = abort_pend;
         assign tx_payload[32 * n +: 32] = txdat[n];
      end
   endgenerate

   // Highest priority pending buffer; the higher index wins a tie.
   always_comb begin
      tx_sel = '0;
      for (int i = 0; i < cms_pkg::NUM_TXBUF; i++) begin
         if (req[i] && !tx_abort_req[i] && (!tx_sel.valid
             || txcon[i][1:0] >= txcon[tx_sel.idx][1:0])) begin
            tx_sel.valid = 1'b1;
            tx_sel.idx = 2'(i);
         end
      end
   end

   // ========================================================
   // Read data, captured in the setup phase
   logic [31:0] next_rdata;

   // Unmapped addresses read as zero.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_mode) begin
         next_rdata[7:0] = {mode_ctrl[7:5], win_sel};
      end
      if (hit_stat) begin
         next_rdata[7:0] = comm_stat;
      end
      if (hit_op) begin
         next_rdata[2:0] = op_req;
         next_rdata[cms_pkg::OPST_LSB +: 3] = operating_mode_status;
      end
      if (hit_cnt) begin
         next_rdata[8:0] = tec;
         next_rdata[cms_pkg::REC_LSB +: 8] = rec;
      end
      for (int i = 0; i < cms_pkg::NUM_TXBUF; i++) begin
         if (hit_txcon[i]) begin
            next_rdata[7:0] = txcon[i];
         end
         if (hit_txdat[i]) begin
            next_rdata = txdat[i];
         end
      end
   end

   // Read data register, loaded on the setup cycle of every transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= next_rdata;
      end
   end

endmodule : cms_ctrl

`default_nettype wire

// [bench/cms_ctrl_checker.sv]
// Assertion checker for the CAN mode, status and transmit control block.
`timescale 1ns/100ps
`default_nettype none
module cms_ctrl_checker (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB side.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   // Engine and mode side.
   input wire logic bus_idle,
   input wire cms_pkg::cms_tx_ev_t tx_ev,
   input wire cms_pkg::cms_tx_sel_t tx_sel,
   input wire logic [2:0] tx_abort_req,
   input wire logic fifo_watermark_irq,
   input wire logic [1:0] active_mode,
   input wire logic [2:0] operating_mode_status
);
   // ==========================================================
   // Helpers
   // A read access phase, and the status register being read.
   logic rd_acc;
   logic rd_stat;
   logic in_cfg;
   assign rd_acc = psel && penable && !pwrite;
   assign rd_stat = rd_acc && paddr == 8'h04;
   assign in_cfg = operating_mode_status == cms_pkg::OPC_CONFIG;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Assertions
   mode_apply_a: assert property (
      $changed(active_mode) |-> !in_cfg && ($past(in_cfg) || $past(in_cfg, 2)))
      else $error("Mode changed outside config exit.");
   cfg_idle_a: assert property (
      in_cfg && !$past(in_cfg) |-> $past(bus_idle))
      else $error("Config entered on a busy bus.");
   warn_or_a: assert property (
      rd_stat |-> prdata[0] == (prdata[1] || prdata[2]))
      else $error("Combined warning wrong.");
   warn_excl_a: assert property (
      rd_stat |-> !(prdata[2] && prdata[4]) && !(prdata[1] && prdata[3]))
      else $error("Warning while error passive.");
   legacy_win_a: assert property (
      rd_acc && paddr == 8'h00
      && active_mode == cms_pkg::MD_LEGACY |-> prdata[4:0] == 5'h00)
      else $error("Legacy window not zero.");
   legacy_done_a: assert property (
      rd_acc && paddr inside {8'h08, 8'h0c, 8'h10}
      && active_mode == cms_pkg::MD_LEGACY |-> !prdata[7])
      else $error("Done flag in legacy mode.");
   done_release_a: assert property (
      tx_ev.done && tx_sel.valid && tx_sel.idx == tx_ev.idx
      |=> !(tx_sel.valid && tx_sel.idx == $past(tx_ev.idx)))
      else $error("Finished buffer still selected.");
   fifo_only_a: assert property (
      active_mode != cms_pkg::MD_FIFO |-> !fifo_watermark_irq)
      else $error("Watermark outside FIFO mode.");

   // Main scenarios reached.
   done_c: cover property (tx_ev.done);
   abort_c: cover property (tx_abort_req != 3'h0);
   cfg_c: cover property (in_cfg && !$past(in_cfg));
endmodule : cms_ctrl_checker

bind cms_ctrl cms_ctrl_checker i_chk (.*);
`default_nettype wire

// [bench/cms_can_model.sv]
// CAN engine and bus model facing the block.
`timescale 1ns/100ps
`default_nettype none
module cms_can_model (
   // Clock.
   input wire logic pclk,
   // Engine side of the block.
   input wire logic [2:0] tx_abort_req,
   output cms_pkg::cms_fault_ev_t fault_ev,
   output cms_pkg::cms_tx_ev_t tx_ev,
   output logic bus_idle
);
   // Engine starts quiet with the bus idle.
   initial begin
      fault_ev = '0;
      tx_ev = '0;
      bus_idle = 1'b1;
   end

   // Pulses one fault event n times.
   task automatic fault(input cms_pkg::cms_fault_ev_t ev, input int n);
      repeat (n) begin
         @(posedge pclk);
         fault_ev <= ev;
         @(posedge pclk);
         fault_ev <= '0;
      end
   endtask : fault

   // Reports one transmit outcome for one buffer.
   task automatic tx(input cms_pkg::cms_tx_ev_t ev);
      @(posedge pclk);
      tx_ev <= ev;
      @(posedge pclk);
      tx_ev <= '0;
   endtask : tx

   // Withdraws a frame once the block asks to abort.
   task automatic withdraw(input int i);
      int n = 0;
      while (!tx_abort_req[i] && n < 20) begin
         @(posedge pclk);
         n++;
      end
      tx({4'h1, 2'(i)});
   endtask : withdraw
endmodule : cms_can_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the CAN mode, status and transmit control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ovf0 = 1'b0;
   logic ovf1 = 1'b0;
   logic [3:0] fifo_len = 4'h8;
   logic [3:0] fifo_used = 4'h0;
   cms_pkg::cms_fault_ev_t fault_ev;
   cms_pkg::cms_tx_ev_t tx_ev;
   cms_pkg::cms_tx_sel_t tx_sel;
   cms_pkg::cms_window_t win;
   logic bus_idle;
   logic irq;
   logic [2:0] abort_req;
   logic [2:0] op_st;
   logic [1:0] act_mode;
   int err_count = 0;
   int checks = 0;

   // Clock of 100 MHz.
   always #5 pclk = ~pclk;

   cms_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bus_idle, .fault_ev, .tx_ev,
      .tx_sel, .tx_abort_req(abort_req), .tx_payload(),
      .rx_buf0_overflow(ovf0), .rx_buf1_overflow(ovf1),
      .rx_fifo_len(fifo_len), .rx_fifo_used(fifo_used),
      .fifo_watermark_irq(irq), .active_mode(act_mode),
      .operating_mode_status(op_st), .window_map(win));
   cms_can_model i_can (.pclk, .tx_abort_req(abort_req), .fault_ev,
      .tx_ev, .bus_idle);

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // Compares one value and counts it.
   task automatic cmp(input string s, input logic [31:0] e, q);
      checks++;
      if (q !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", s, e, q);
      end
   endtask : cmp

   // One APB transfer: setup, then access until pready.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      if (n >= 50) begin
         err_count++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      cmp($sformatf("read %h", a), e, q);
   endtask : rd

   // Writes a mode request; the state register follows one edge later.
   task automatic op(input logic [2:0] c);
      wr(cms_pkg::OFS_OPMODE, 32'(c));
      @(posedge pclk);
      #1;
   endtask : op

   // Reset values and a missing address.
   task automatic s_reset();
      rd(8'h00, 32'h0000_0000);
      rd(cms_pkg::OFS_OPMODE, 32'h0000_0404);
      rd(8'h04, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
   endtask : s_reset

   // Mode select, windows and status codes.
   task automatic s_mode();
      // Upper three bits: expected window class in enum order.
      logic [7:0] pair [8] = '{8'h20, 8'h21, 8'h42, 8'h26, 8'h29, 8'hb7,
         8'h0a, 8'h18};
      wr(8'h00, 32'h0000_0050);
      cmp("mode", 32'h0000_0000, 32'(act_mode));
      op(3'h0);
      cmp("mode", 32'h0000_0001, 32'(act_mode));
      cmp("win", 32'(cms_pkg::WIN_RXBUF), 32'(win.kind));
      wr(8'h00, 32'h0000_0083);
      rd(8'h00, 32'h0000_0043);
      cmp("win", 32'(cms_pkg::WIN_TXBUF), 32'(win.kind));
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, {24'h00_0000, 3'h2, pair[i][4:0]});
         cmp("win", 32'(pair[i][7:5]), 32'(win.kind));
      end
      for (int c = 3; c >= 0; c--) begin
         op(3'(c));
         cmp("opmode", 32'(c), 32'(op_st));
      end
      i_can.bus_idle = 1'b0;
      op(3'h4);
      repeat (4) @(posedge pclk);
      #1;
      cmp("opmode", 32'h0000_0000, 32'(op_st));
      i_can.bus_idle = 1'b1;
      for (int n = 0; n < 10 && op_st !== 3'h4; n++) @(posedge pclk);
      #1;
      cmp("opmode", 32'h0000_0004, 32'(op_st));
      op(3'h0);
   endtask : s_mode

   // Error counter thresholds and bus-off recovery.
   task automatic s_err();
      i_can.fault(5'h08, 12);
      rd(8'h04, 32'h0000_0005);
      i_can.fault(5'h08, 4);
      rd(8'h04, 32'h0000_0010);
      i_can.fault(5'h08, 16);
      rd(8'h04, 32'h0000_0030);
      rd(8'h18, 32'h0000_0100);
      i_can.fault(5'h01, 128);
      rd(8'h18, 32'h0000_0000);
      i_can.fault(5'h02, 96);
      rd(8'h04, 32'h0000_0003);
   endtask : s_err

   // Transmit buffer control.
   task automatic s_tx();
      wr(8'h08, 32'h0000_000b);
      wr(8'h0c, 32'h0000_0009);
      cmp("sel", 32'h0000_0004, 32'(tx_sel));
      i_can.tx({4'h8, 2'h0});
      rd(8'h08, 32'h0000_0083);
      cmp("sel", 32'h0000_0005, 32'(tx_sel));
      wr(8'h0c, 32'h0000_000a);
      rd(8'h0c, 32'h0000_0009);
      wr(8'h0c, 32'h0000_0001);
      cmp("abort", 32'h0000_0002, 32'(abort_req));
      i_can.withdraw(1);
      rd(8'h0c, 32'h0000_0041);
      wr(8'h08, 32'h0000_008b);
      i_can.tx({4'h4, 2'h0});
      i_can.tx({4'h2, 2'h0});
      i_can.tx({4'h8, 2'h0});
      rd(8'h08, 32'h0000_00b3);
      wr(8'h08, 32'h0000_000b);
      rd(8'h08, 32'h0000_000b);
   endtask : s_tx

   // Overflow flags in enhanced legacy mode.
   task automatic s_ovf();
      @(posedge pclk);
      ovf0 <= 1'b1;
      ovf1 <= 1'b1;
      @(posedge pclk);
      ovf0 <= 1'b0;
      ovf1 <= 1'b0;
      rd(8'h04, 32'h0000_0043);
      wr(8'h04, 32'h0000_0000);
      rd(8'h04, 32'h0000_0003);
   endtask : s_ovf

   // Main sequence.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_mode();
      s_err();
      s_tx();
      s_ovf();
      complete_run();
   end
endmodule : tb
`default_nettype wire
